// [hw/ptsu_pkg.sv]
// Purpose: shared constants for the ptp time stamp unit
// Assumes: 250 MHz system clock, 50 MHz time base clock, mii link clock
// Notes:   all offsets, counts and encodings live here
`default_nettype none
package ptsu_pkg;
  localparam int unsigned       SYS_CLK_HZ     = 250_000_000;
  localparam int unsigned       TB_CLK_HZ      = 50_000_000;
  localparam logic [29:0]       NS_STEP        = 30'd20;
  localparam logic [29:0]       NS_PER_SEC     = 30'd1_000_000_000;
  localparam int unsigned       PPS_WIDTH_NS   = 100_000_000;
  localparam int unsigned       PPS_WIDTH_CYC  = PPS_WIDTH_NS / 20;
  localparam logic [15:0]       ETYPE_PTP      = 16'h88f7;
  localparam logic [15:0]       ETYPE_IPV4     = 16'h0800;
  localparam logic [7:0]        IP_PROTO_UDP   = 8'h11;
  localparam logic [15:0]       UDP_PORT_EVENT = 16'h013f;
  localparam logic [3:0]        MSG_SYNC       = 4'h0;
  localparam logic [10:0]       OFF_ETYPE      = 11'd12;
  localparam logic [10:0]       OFF_IPPROTO    = 11'd23;
  localparam logic [10:0]       OFF_UDPDPORT   = 11'd36;
  localparam logic [10:0]       OFF_L2_PTP     = 11'd14;
  localparam logic [10:0]       L3_HDR_BYTES   = 11'd28;
  localparam logic [10:0]       OFF_L3_PTP     = OFF_L2_PTP + L3_HDR_BYTES;
  localparam logic [10:0]       OFF_ORIG_TS    = 11'd34;
  localparam logic [10:0]       ORIG_TS_BYTES  = 11'd10;
  localparam logic [7:0]        SFD_BYTE       = 8'hd5;
  localparam int unsigned       STAMP_W        = 78;
  localparam int unsigned       STAMP_DEPTH    = 4;
endpackage
`default_nettype wire

// [hw/ptsu_stamp_mem.sv]
// Purpose: small stamp store, one slot per direction and message kind
// Assumes: single clock, one write and one read port
// Notes:   read data is registered
`default_nettype none
module ptsu_stamp_mem
  import ptsu_pkg::*;
(
  input  wire logic               clock_i,
  input  wire logic               wr_en_i,
  input  wire logic [1:0]         wr_addr_i,
  input  wire logic [STAMP_W-1:0] wr_data_i,
  input  wire logic [1:0]         rd_addr_i,
  output logic      [STAMP_W-1:0] rd_data_o
);
  logic [STAMP_W-1:0] mem_q [STAMP_DEPTH];

  always_ff @(posedge clock_i) begin
    if (wr_en_i) begin
      mem_q[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clock_i) begin
    rd_data_o <= mem_q[rd_addr_i];
  end
endmodule
`default_nettype wire

// [hw/ptsu_mii_rx_parse.sv]
// Purpose: nibble-to-byte assembly and ptp frame recognition on one mii direction
// Assumes: runs on the mii link clock, nibbles low first after the sfd
// Notes:   pulses sof at sfd, ptp_o at end of the message type byte
`default_nettype none
module ptsu_mii_rx_parse
  import ptsu_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       reset_i,
  input  wire logic       dv_i,
  input  wire logic [3:0] nib_i,
  output logic            sof_o,
  output logic            ptp_o,
  output logic            sync_o,
  output logic            l3_o
);
  logic       in_frame_q;
  logic       half_q;
  logic [3:0] low_q;
  logic [7:0] pre_q;
  logic [10:0] idx_q;
  logic [7:0] prev_q;
  logic       l2_q;
  logic       ip_q;
  logic       udp_q;
  logic       byte_v;
  logic [7:0] byte_d;

  assign byte_v = in_frame_q && half_q && dv_i;
  assign byte_d = {nib_i, low_q};

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      in_frame_q <= 1'b0;
      half_q     <= 1'b0;
      low_q      <= 4'h0;
      pre_q      <= 8'h00;
      idx_q      <= 11'd0;
      sof_o      <= 1'b0;
    end else begin
      sof_o <= 1'b0;
      pre_q <= {nib_i, pre_q[7:4]};
      if (!dv_i) begin
        in_frame_q <= 1'b0;
        half_q     <= 1'b0;
        pre_q      <= 8'h00;
      end else if (!in_frame_q) begin
        if ({nib_i, pre_q[7:4]} == SFD_BYTE) begin
          in_frame_q <= 1'b1;
          half_q     <= 1'b0;
          idx_q      <= 11'd0;
          sof_o      <= 1'b1;
        end
      end else begin
        half_q <= ~half_q;
        low_q  <= nib_i;
        if (half_q && idx_q != 11'h7ff) begin
          idx_q <= idx_q + 11'd1;
        end
      end
    end
  end

  // classify the frame by ethertype, ip protocol and udp event port
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      prev_q <= 8'h00;
      l2_q   <= 1'b0;
      ip_q   <= 1'b0;
      udp_q  <= 1'b0;
      ptp_o  <= 1'b0;
      sync_o <= 1'b0;
      l3_o   <= 1'b0;
    end else begin
      ptp_o <= 1'b0;
      if (sof_o) begin
        l2_q  <= 1'b0;
        ip_q  <= 1'b0;
        udp_q <= 1'b0;
      end
      if (byte_v) begin
        prev_q <= byte_d;
        if (idx_q == OFF_ETYPE + 11'd1) begin
          l2_q <= {prev_q, byte_d} == ETYPE_PTP;
          ip_q <= {prev_q, byte_d} == ETYPE_IPV4;
        end
        if (idx_q == OFF_IPPROTO && byte_d != IP_PROTO_UDP) begin
          ip_q <= 1'b0;
        end
        if (idx_q == OFF_UDPDPORT + 11'd1) begin
          udp_q <= ip_q && ({prev_q, byte_d} == UDP_PORT_EVENT);
        end
        if (idx_q == OFF_L2_PTP && l2_q) begin
          ptp_o  <= 1'b1;
          sync_o <= byte_d[3:0] == MSG_SYNC;
          l3_o   <= 1'b0;
        end
        if (idx_q == OFF_L3_PTP && udp_q) begin
          ptp_o  <= 1'b1;
          sync_o <= byte_d[3:0] == MSG_SYNC;
          l3_o   <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [hw/ptsu_top.sv]
// Purpose: ptp hardware time stamp unit on the mii between line_transceiver and mac
// Assumes: clock_i is the 50 MHz pll clock in hardware; bench runs it at 250 MHz
// Notes:   mii taps on the link clock; stamps cross by toggle handshake
`default_nettype none
// Behaviour
// - mii traffic is observed passively, ordinary frames leave unchanged
// - each valid ptp frame gets a stamp held for the host_computer to read, except a transmit one whose event meets a receive one in the same cycle
// - stamps are taken at frame start for both transmit and receive
// - link logic is nibble based and works at 10 or 100 Mbit/s
// - host_computer exchange travels over usb, outside this block
// - master: seconds load once after power-up, nanoseconds cleared together
// - master: nanoseconds cleared again when reference oscillator is nominal
// - master: second pulse follows the ns wrap, within one 20 ns tick
// - time base advances on the 50 MHz pll clock
// - slave: decoded master seconds and nanoseconds load both counters
// - one-step inserts the transmit stamp into outgoing sync, else two-step
// - ptp in raw 802.3 frames and in udp over ipv4 both recognised
module ptsu_top
  import ptsu_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  input  wire logic        mii_clk_i,
  input  wire logic        mii_reset_i,
  input  wire logic        rx_dv_i,
  input  wire logic [3:0]  rx_nib_i,
  input  wire logic        tx_en_i,
  input  wire logic [3:0]  tx_nib_i,
  output logic             tx_en_o,
  output logic [3:0]       tx_nib_o,
  input  wire logic        master_mode_i,
  input  wire logic        one_step_i,
  input  wire logic        ref_sec_valid_i,
  input  wire logic [47:0] ref_sec_i,
  input  wire logic        ref_osc_nominal_i,
  input  wire logic        slave_set_i,
  input  wire logic [47:0] slave_sec_i,
  input  wire logic [29:0] slave_ns_i,
  input  wire logic [1:0]  stamp_sel_i,
  output logic [77:0]      stamp_o,
  output logic [3:0]       stamp_new_o,
  output logic [47:0]      seconds_o,
  output logic [29:0]      nanoseconds_o,
  output logic             second_pulse_output
);
  typedef enum logic [1:0] {PTSU_WAIT_REF, PTSU_WAIT_NOM, PTSU_RUN} ptsu_tb_state_t;

  ptsu_tb_state_t tb_state_q;
  logic [47:0] sec_q;
  logic [29:0] ns_q;
  logic [29:0] ns_inc;
  logic        wrap;
  logic [2:0]  refv_q;
  logic [1:0]  nom_q;
  logic [22:0] pps_cnt_q;

  // ---------------- link side: both directions parsed on the mii clock
  logic rx_dv_q;
  logic [3:0] rx_nib_q;
  logic tx_dv_q;
  logic [3:0] tx_nib_q;
  logic rx_sof;
  logic rx_ptp;
  logic rx_sync;
  logic rx_l3;
  logic tx_sof;
  logic tx_ptp;
  logic tx_sync;
  logic tx_l3;

  // mii inputs are in the link domain already; one register level only
  always_ff @(posedge mii_clk_i) begin
    rx_dv_q  <= rx_dv_i;
    rx_nib_q <= rx_nib_i;
    tx_dv_q  <= tx_en_i;
    tx_nib_q <= tx_nib_i;
  end

  ptsu_mii_rx_parse u_rx_parse (
    .clock_i (mii_clk_i),
    .reset_i (mii_reset_i),
    .dv_i    (rx_dv_q),
    .nib_i   (rx_nib_q),
    .sof_o   (rx_sof),
    .ptp_o   (rx_ptp),
    .sync_o  (rx_sync),
    .l3_o    (rx_l3)
  );

  ptsu_mii_rx_parse u_tx_parse (
    .clock_i (mii_clk_i),
    .reset_i (mii_reset_i),
    .dv_i    (tx_dv_q),
    .nib_i   (tx_nib_q),
    .sof_o   (tx_sof),
    .ptp_o   (tx_ptp),
    .sync_o  (tx_sync),
    .l3_o    (tx_l3)
  );

  // link events cross to the time base clock as toggles
  logic [1:0] sof_tgl_q;
  logic [1:0] ptp_tgl_q;
  logic [1:0] ptp_sync_q;

  always_ff @(posedge mii_clk_i) begin
    if (mii_reset_i) begin
      sof_tgl_q  <= 2'b00;
      ptp_tgl_q  <= 2'b00;
      ptp_sync_q <= 2'b00;
    end else begin
      if (rx_sof) sof_tgl_q[0] <= ~sof_tgl_q[0];
      if (tx_sof) sof_tgl_q[1] <= ~sof_tgl_q[1];
      if (rx_ptp) begin
        ptp_tgl_q[0]  <= ~ptp_tgl_q[0];
        ptp_sync_q[0] <= rx_sync;
      end
      if (tx_ptp) begin
        ptp_tgl_q[1]  <= ~ptp_tgl_q[1];
        ptp_sync_q[1] <= tx_sync;
      end
    end
  end

  logic [1:0] sof_s1_q;
  logic [1:0] sof_s2_q;
  logic [1:0] sof_s3_q;
  logic [1:0] ptp_s1_q;
  logic [1:0] ptp_s2_q;
  logic [1:0] ptp_s3_q;
  logic [1:0] sof_ev;
  logic [1:0] ptp_ev;

  always_ff @(posedge clock_i) begin
    sof_s1_q <= sof_tgl_q;
    sof_s2_q <= sof_s1_q;
    sof_s3_q <= sof_s2_q;
    ptp_s1_q <= ptp_tgl_q;
    ptp_s2_q <= ptp_s1_q;
    ptp_s3_q <= ptp_s2_q;
  end

  assign sof_ev = sof_s2_q ^ sof_s3_q;
  assign ptp_ev = ptp_s2_q ^ ptp_s3_q;

  // ---------------- time base
  always_ff @(posedge clock_i) begin
    refv_q <= {refv_q[1:0], ref_sec_valid_i};
    nom_q  <= {nom_q[0], ref_osc_nominal_i};
  end

  assign ns_inc = ns_q + NS_STEP;
  assign wrap   = ns_inc >= NS_PER_SEC;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      tb_state_q <= PTSU_WAIT_REF;
      sec_q      <= 48'h0;
      ns_q       <= 30'h0;
    end else begin
      ns_q <= wrap ? 30'h0 : ns_inc;
      if (wrap) sec_q <= sec_q + 48'h1;
      case (tb_state_q)
        PTSU_WAIT_REF: begin
          if (master_mode_i && refv_q[1] && !refv_q[2]) begin
            sec_q      <= ref_sec_i;
            ns_q       <= 30'h0;
            tb_state_q <= PTSU_WAIT_NOM;
          end
        end
        PTSU_WAIT_NOM: begin
          if (nom_q[1]) begin
            ns_q       <= 30'h0;
            tb_state_q <= PTSU_RUN;
          end
        end
        PTSU_RUN: begin
        end
        default: tb_state_q <= PTSU_WAIT_REF;
      endcase
      if (!master_mode_i && slave_set_i) begin
        sec_q <= slave_sec_i;
        ns_q  <= slave_ns_i;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      pps_cnt_q           <= 23'h0;
      second_pulse_output <= 1'b0;
    end else if (wrap) begin
      pps_cnt_q           <= 23'(PPS_WIDTH_CYC - 1);
      second_pulse_output <= 1'b1;
    end else if (pps_cnt_q != 23'h0) begin
      pps_cnt_q <= pps_cnt_q - 23'h1;
    end else begin
      second_pulse_output <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      seconds_o     <= 48'h0;
      nanoseconds_o <= 30'h0;
    end else begin
      seconds_o     <= sec_q;
      nanoseconds_o <= ns_q;
    end
  end

  // ---------------- stamp capture: taken at sof, kept if frame is ptp
  logic [STAMP_W-1:0] pend_q [2];
  logic               wr_en;
  logic [1:0]         wr_addr;
  logic [STAMP_W-1:0] wr_data;

  always_ff @(posedge clock_i) begin
    for (int d = 0; d < 2; d++) begin
      if (sof_ev[d]) pend_q[d] <= {sec_q, ns_q};
    end
  end

  always_comb begin
    wr_en   = 1'b0;
    wr_addr = 2'b00;
    wr_data = pend_q[0];
    if (ptp_ev[0]) begin
      wr_en   = 1'b1;
      wr_addr = {1'b0, ptp_sync_q[0]};
    end else if (ptp_ev[1]) begin
      wr_en   = 1'b1;
      wr_addr = {1'b1, ptp_sync_q[1]};
      wr_data = pend_q[1];
    end
  end

  ptsu_stamp_mem u_mem (
    .clock_i   (clock_i),
    .wr_en_i   (wr_en),
    .wr_addr_i (wr_addr),
    .wr_data_i (wr_data),
    .rd_addr_i (stamp_sel_i),
    .rd_data_o (stamp_o)
  );

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      stamp_new_o <= 4'h0;
    end else begin
      stamp_new_o <= 4'h0;
      if (wr_en) stamp_new_o[wr_addr] <= 1'b1;
    end
  end

  // ---------------- one-step: overwrite origin stamp of outgoing sync
  logic [79:0] ins_q;
  logic [2:0]  ins_s_q;
  logic        ins_tgl_q;
  logic        ins_ack_q;
  logic [10:0] tx_idx_q;
  logic        tx_half_q;
  logic        tx_run_q;
  logic [79:0] ins_sh_q;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      ins_tgl_q <= 1'b0;
      ins_q     <= 80'h0;
    end else if (sof_ev[1]) begin
      ins_q     <= {sec_q, 2'b00, ns_q};
      ins_tgl_q <= ~ins_tgl_q;
    end
  end

  // stamp word is stable long before the sync origin field arrives
  always_ff @(posedge mii_clk_i) begin
    ins_s_q <= {ins_s_q[1:0], ins_tgl_q};
  end

  always_ff @(posedge mii_clk_i) begin
    if (mii_reset_i) begin
      tx_idx_q  <= 11'd0;
      tx_half_q <= 1'b0;
      tx_run_q  <= 1'b0;
      ins_ack_q <= 1'b0;
      ins_sh_q  <= 80'h0;
      tx_en_o   <= 1'b0;
      tx_nib_o  <= 4'h0;
    end else begin
      if (ins_s_q[2] != ins_s_q[1]) ins_ack_q <= 1'b1;
      // the nibble held beside the sof pulse is already byte 0 low
      if (tx_sof) begin
        tx_idx_q  <= 11'd0;
        tx_half_q <= 1'b1;
        tx_run_q  <= 1'b0;
      end else if (tx_dv_q) begin
        tx_half_q <= ~tx_half_q;
        if (tx_half_q) tx_idx_q <= tx_idx_q + 11'd1;
      end
      if (tx_ptp && tx_sync && one_step_i && ins_ack_q) begin
        tx_run_q  <= 1'b1;
        ins_ack_q <= 1'b0;
        ins_sh_q  <= ins_q;
      end
      tx_en_o  <= tx_dv_q;
      tx_nib_o <= tx_nib_q;
      if (tx_run_q && tx_dv_q) begin
        if (tx_idx_q >= (tx_l3 ? OFF_L3_PTP : OFF_L2_PTP) + OFF_ORIG_TS &&
            tx_idx_q <  (tx_l3 ? OFF_L3_PTP : OFF_L2_PTP) + OFF_ORIG_TS + ORIG_TS_BYTES) begin
          tx_nib_o <= tx_half_q ? ins_sh_q[79:76] : ins_sh_q[75:72];
          if (tx_half_q) ins_sh_q <= {ins_sh_q[71:0], 8'h00};
        end
      end
    end
  end
endmodule
`default_nettype wire

// [testbench/ptsu_top_properties.sv]
// Purpose: concurrent checks on the time stamp unit ports
// Assumes: config inputs change rarely, bench holds slave values steady
// Notes:   bound to ptsu_top from tb_top
`default_nettype none
module ptsu_top_properties
  import ptsu_pkg::*;
(
  input wire logic        clock_i,
  input wire logic        reset_i,
  input wire logic        mii_clk_i,
  input wire logic        mii_reset_i,
  input wire logic        tx_en_i,
  input wire logic [3:0]  tx_nib_i,
  input wire logic        tx_en_o,
  input wire logic [3:0]  tx_nib_o,
  input wire logic        master_mode_i,
  input wire logic        one_step_i,
  input wire logic        ref_sec_valid_i,
  input wire logic        ref_osc_nominal_i,
  input wire logic        slave_set_i,
  input wire logic [47:0] slave_sec_i,
  input wire logic [29:0] slave_ns_i,
  input wire logic [3:0]  stamp_new_o,
  input wire logic [47:0] seconds_o,
  input wire logic [29:0] nanoseconds_o,
  input wire logic        second_pulse_output
);
  localparam logic [29:0] NS_LAST = NS_PER_SEC - NS_STEP;
  logic [3:0] now_w;
  logic [3:0] prev_q;
  logic [3:0] quiet_q;
  logic       calm_w;
  assign now_w = {master_mode_i, ref_sec_valid_i, ref_osc_nominal_i, slave_set_i & ~master_mode_i};
  // calm: no time load can be under way
  assign calm_w = quiet_q[3] && (now_w == prev_q);
  always_ff @(posedge clock_i) begin
    prev_q <= now_w;
  end
  always_ff @(posedge clock_i) begin
    if (reset_i || now_w != prev_q) begin
      quiet_q <= 4'h0;
    end else if (quiet_q != 4'hf) begin
      quiet_q <= quiet_q + 4'h1;
    end
  end
  chk_ns_step: assert property (@(posedge clock_i) disable iff (reset_i)
    calm_w && nanoseconds_o != NS_LAST |=>
      nanoseconds_o == $past(nanoseconds_o) + NS_STEP && $stable(seconds_o))
    else $error("ns step or seconds hold wrong");
  chk_ns_wrap: assert property (@(posedge clock_i) disable iff (reset_i)
    calm_w && nanoseconds_o == NS_LAST |=>
      nanoseconds_o == 30'h0 && seconds_o == $past(seconds_o) + 48'h1)
    else $error("ns wrap wrong");
  chk_pulse_wrap: assert property (@(posedge clock_i) disable iff (reset_i)
    calm_w && nanoseconds_o == NS_LAST |-> ##[1:3] second_pulse_output)
    else $error("second pulse missing at wrap");
  chk_pulse_src: assert property (@(posedge clock_i) disable iff (reset_i)
    $rose(second_pulse_output) |-> ##1 nanoseconds_o == 30'h0)
    else $error("second pulse away from wrap");
  chk_slave_load: assert property (@(posedge clock_i) disable iff (reset_i)
    !master_mode_i && $rose(slave_set_i) |-> ##[1:6]
      (seconds_o == slave_sec_i && nanoseconds_o - slave_ns_i <= 30'd120))
    else $error("slave time not loaded");
  chk_new_pulse: assert property (@(posedge clock_i) disable iff (reset_i)
    stamp_new_o != 4'h0 |-> $onehot(stamp_new_o) ##1 stamp_new_o == 4'h0)
    else $error("stamp pulse malformed");
  chk_tx_en_pass: assert property (@(posedge mii_clk_i) disable iff (mii_reset_i)
    tx_en_o == $past(tx_en_i, 2))
    else $error("tx enable altered");
  chk_tx_nib_pass: assert property (@(posedge mii_clk_i) disable iff (mii_reset_i)
    !one_step_i && $past(tx_en_i, 2) |-> tx_nib_o == $past(tx_nib_i, 2))
    else $error("tx data altered");
endmodule
`default_nettype wire

// [testbench/ptsu_mii_partner.sv]
// Purpose: mac and line_transceiver model on both mii directions
// Assumes: link clock runs only around frames, 160 ns period
// Notes:   captures transmit nibbles leaving the unit into cap
`default_nettype none
module ptsu_mii_partner
  import ptsu_pkg::*;
(
  output logic            mii_clk_o = 1'b0,
  output logic            rx_dv_o = 1'b0,
  output logic [3:0]      rx_nib_o = 4'h0,
  output logic            tx_en_o = 1'b0,
  output logic [3:0]      tx_nib_o = 4'h0,
  input  wire logic       tx_en_i,
  input  wire logic [3:0] tx_nib_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cap[$];
  always @(posedge mii_clk_o) if (tx_en_i) cap.push_back(tx_nib_i);
  // one nibble a link clock, idle side shows changing data
  task automatic put(input logic tx, input logic en, input logic [3:0] n);
    #80 mii_clk_o = 1'b1;
    if (tx) begin
      tx_en_o <= en;
      tx_nib_o <= n;
      rx_nib_o <= ~rx_nib_o;
    end else begin
      rx_dv_o <= en;
      rx_nib_o <= n;
      tx_nib_o <= ~tx_nib_o;
    end
    #80 mii_clk_o = 1'b0;
  endtask
  // kind 0 raw ptp, 1 ptp over udp, 2 other traffic
  function automatic logic [7:0] fbyte(input int j, input int kind, input logic [3:0] msg);
    case (j - 8)
      -1: return SFD_BYTE;
      12: return (kind == 1) ? ETYPE_IPV4[15:8] : (kind == 2) ? 8'h86 : ETYPE_PTP[15:8];
      13: return (kind == 1) ? ETYPE_IPV4[7:0] : (kind == 2) ? 8'hdd : ETYPE_PTP[7:0];
      23: if (kind == 1) return IP_PROTO_UDP;
      36: if (kind == 1) return UDP_PORT_EVENT[15:8];
      37: if (kind == 1) return UDP_PORT_EVENT[7:0];
      default: ;
    endcase
    if (j < 7) return 8'h55;
    if (j - 8 == ((kind == 1) ? 42 : 14)) return {4'h0, msg};
    return 8'(j) ^ 8'h5a;
  endfunction
  task automatic send(input logic tx, input int kind, input logic [3:0] msg);
    logic [7:0] b;
    #1;
    cap.delete();
    repeat (4) put(tx, 1'b0, ~(tx ? tx_nib_o : rx_nib_o));
    for (int j = 0; j < ((kind == 1) ? 42 : 14) + 54; j++) begin
      b = fbyte(j, kind, msg);
      put(tx, 1'b1, b[3:0]);
      put(tx, 1'b1, b[7:4]);
    end
    repeat (6) put(tx, 1'b0, ~(tx ? tx_nib_o : rx_nib_o));
  endtask
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
// Purpose: self checking bench for the ptp time stamp unit
// Assumes: 250 MHz clock_i, link clock from the partner model
// Notes:   stamps judged against the time seen before each frame
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ptsu_pkg::*;
  logic            clock_i = 1'b0;
  logic            reset_i = 1'b1;
  logic            mii_reset_i = 1'b1;
  logic            master_mode_i = 1'b1;
  logic            one_step_i = 1'b0;
  logic            ref_sec_valid_i = 1'b0;
  logic            ref_osc_nominal_i = 1'b0;
  logic            slave_set_i = 1'b0;
  logic [47:0]     ref_sec_i = 48'h0;
  logic [47:0]     slave_sec_i = 48'h0;
  logic [29:0]     slave_ns_i = 30'h0;
  logic [1:0]      stamp_sel_i = 2'h0;
  logic [3:0]      last_new = 4'h0;
  wire logic       mii_clk_i, rx_dv_i, tx_en_i, tx_en_o, second_pulse_output;
  wire logic [3:0] rx_nib_i, tx_nib_i, tx_nib_o, stamp_new_o;
  wire logic [77:0] stamp_o;
  wire logic [47:0] seconds_o;
  wire logic [29:0] nanoseconds_o;
  int              num_errors = 0;
  int              samples_checked = 0;
  int              cycles = 0;
  int              npulse = 0;
  ptsu_top dut (.clock_i, .reset_i, .mii_clk_i, .mii_reset_i, .rx_dv_i, .rx_nib_i, .tx_en_i,
    .tx_nib_i, .tx_en_o, .tx_nib_o, .master_mode_i, .one_step_i, .ref_sec_valid_i, .ref_sec_i,
    .ref_osc_nominal_i, .slave_set_i, .slave_sec_i, .slave_ns_i, .stamp_sel_i, .stamp_o,
    .stamp_new_o, .seconds_o, .nanoseconds_o, .second_pulse_output);
  ptsu_mii_partner mii (.mii_clk_o(mii_clk_i), .rx_dv_o(rx_dv_i), .rx_nib_o(rx_nib_i),
    .tx_en_o(tx_en_i), .tx_nib_o(tx_nib_i), .tx_en_i(tx_en_o), .tx_nib_i(tx_nib_o));
  initial forever #2 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cycles++;
    if (stamp_new_o != 4'h0) begin
      npulse++;
      last_new = stamp_new_o;
    end
    if (cycles == 90000) begin
      num_errors++;
      summarize();
    end
  end
  task automatic check(input string what, input logic [79:0] got, input logic [79:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic summarize();
    if (num_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic t_master();
    ref_sec_i <= 48'h0000_1234_5678;
    ref_sec_valid_i <= 1'b1;
    cyc(12);
    check("seconds", seconds_o, 48'h0000_1234_5678);
    check("ns cleared", nanoseconds_o <= 30'd240, 1'b1);
    ref_sec_valid_i <= 1'b0;
    cyc(4);
    ref_sec_i <= 48'h5;
    ref_sec_valid_i <= 1'b1;
    cyc(12);
    check("seconds kept", seconds_o, 48'h0000_1234_5678);
    check("ns running", nanoseconds_o > 30'd400, 1'b1);
    ref_osc_nominal_i <= 1'b1;
    cyc(12);
    check("ns cleared again", nanoseconds_o <= 30'd240, 1'b1);
  endtask
  // slot 4 means no stamp expected
  task automatic t_frame(input logic tx, input int kind, input logic [3:0] msg, input int slot);
    logic [29:0] ns0;
    logic [47:0] s0;
    int          n0;
    ns0 = nanoseconds_o;
    s0 = seconds_o;
    n0 = npulse;
    mii.send(tx, kind, msg);
    cyc(8);
    check("stamp pulses", npulse - n0, (slot < 4) ? 1 : 0);
    if (slot < 4) begin
      check("stamp slot", last_new, 4'h1 << slot);
      stamp_sel_i <= 2'(slot);
      cyc(3);
      check("stamp sec", stamp_o[77:30], s0);
      check("stamp time", (stamp_o[29:0] - ns0) inside {[18000:18160]}, 1'b1);
    end
  endtask
  task automatic t_one_step();
    logic [79:0] got;
    one_step_i <= 1'b1;
    t_frame(1'b1, 0, MSG_SYNC, 3);
    for (int k = 48; k < 58; k++) got = {got[71:0], mii.cap[17 + 2 * k], mii.cap[16 + 2 * k]};
    check("inserted stamp", got, {stamp_o[77:30], 2'b00, stamp_o[29:0]});
    one_step_i <= 1'b0;
  endtask
  task automatic t_slave();
    slave_sec_i <= 48'habcd;
    slave_ns_i <= 30'd999_999_000;
    slave_set_i <= 1'b1;
    cyc(1);
    slave_set_i <= 1'b0;
    cyc(8);
    check("refused in master", seconds_o, 48'h0000_1234_5678);
    master_mode_i <= 1'b0;
    ref_osc_nominal_i <= 1'b0;
    cyc(8);
    slave_set_i <= 1'b1;
    cyc(1);
    slave_set_i <= 1'b0;
    cyc(8);
    check("slave seconds", seconds_o, 48'habcd);
    check("pulse idle", second_pulse_output, 1'b0);
    cyc(50);
    check("seconds on wrap", seconds_o, 48'habce);
    check("ns on wrap", nanoseconds_o < 30'd400, 1'b1);
    check("second pulse", second_pulse_output, 1'b1);
  endtask
  initial begin
    cyc(2);
    reset_i <= 1'b0;
    repeat (3) mii.put(1'b0, 1'b0, 4'ha);
    cyc(1);
    mii_reset_i <= 1'b0;
    t_master();
    t_frame(1'b0, 0, MSG_SYNC, 1);
    t_frame(1'b0, 1, 4'h1, 0);
    t_frame(1'b1, 0, MSG_SYNC, 3);
    t_frame(1'b1, 1, 4'h2, 2);
    t_frame(1'b0, 2, MSG_SYNC, 4);
    t_one_step();
    t_slave();
    summarize();
  end
endmodule
bind ptsu_top ptsu_top_properties chk (.clock_i, .reset_i, .mii_clk_i, .mii_reset_i, .tx_en_i,
  .tx_nib_i, .tx_en_o, .tx_nib_o, .master_mode_i, .one_step_i, .ref_sec_valid_i,
  .ref_osc_nominal_i, .slave_set_i, .slave_sec_i, .slave_ns_i, .stamp_new_o, .seconds_o,
  .nanoseconds_o, .second_pulse_output);
`default_nettype wire
